// ==== hdl/pin_mux_defines.svh ====
// Offsets, field positions, reset values and key of the pin-mux block.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define OFS_PERIPH_CFG     8'h00
`define OFS_DEVICE_STATUS  8'h04
`define OFS_CFG_LOCK       8'h08
`define OFS_GPIO_ENABLE    8'h0c
`define OFS_GPIO_DIRECTION 8'h10
`define OFS_GPIO_OUT       8'h14
`define OFS_GPIO_IN        8'h18

// ==========================================================
// Field positions
`define CFG_AUDIO0_BIT     0
`define CFG_VIDEO1_BIT     1
`define STATUS_ETH_BIT     11
`define GPIO_CLK_A_BIT     1
`define GPIO_CLK_B_BIT     2
`define GPIO_CONV_BIT      8
`define GPIO_MASK          16'h0106
`define HOST_MII_RX_MASK   16'hff00
`define HOST_MII_TX_MASK   16'h007f

// ==========================================================
// Reset values and key
`define PERIPH_CFG_RESET   2'h0
`define GPIO_RESET         16'h0000
`define LOCK_RESET         1'h1
`define UNLOCK_KEY         32'h10c0010c

`endif

// ==== hdl/pin_mux_pkg.sv ====
// Types shared by the pin-mux block.
// Assumes the defines header for all numeric constants.
package pin_mux_pkg;

	// ==========================================================
	// One driven pin: value and output enable
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;

	// ==========================================================
	// Software-visible configuration state
	typedef struct packed {
		logic [1:0]  periph_cfg;
		logic        locked;
		logic [15:0] gpio_pin_enable;
		logic [15:0] gpio_pin_direction;
		logic [15:0] gpio_out;
	} cfg_state_t;

	// ==========================================================
	// Owner of the eight shared video/audio pins
	typedef enum logic [1:0] {
		OWNER_NONE,
		OWNER_VIDEO1,
		OWNER_AUDIO0
	} shared_owner_t;

endpackage

// ==== hdl/pin_sync.sv ====
// Two-flip-flop synchroniser for a bundle of pin inputs.
// Assumes asynchronous pin levels; only the second stage is read.
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// ==========================================================
	// Stages
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	// Data only: no reset, a pin level is meaningless until sampled
	always_ff @(posedge clk_i) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign sync_o = sync_reg;

endmodule

// ==== hdl/strap_latch.sv ====
// Catches a synchronised strap level once, as reset is released.
// Assumes the input already passed a synchroniser on the same clock.
`timescale 1ns/1ps

module strap_latch (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic strap_i,
	output logic      strap_o
);

	// ==========================================================
	// Capture state
	logic value_reg;
	logic value_next;
	logic done_reg;
	logic done_next;

	always_comb begin
		value_next = value_reg;
		done_next  = done_reg;
		if (!done_reg) begin
			value_next = strap_i;
			done_next  = 1'b1;
		end
	end

	// Held until the next reset, whatever the pin does later
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			value_reg <= 1'b0;
			done_reg  <= 1'b0;
		end else begin
			value_reg <= value_next;
			done_reg  <= done_next;
		end
	end

	assign strap_o = value_reg;

endmodule

// ==== hdl/pin_mux_top.sv ====
// Shared pin function multiplexer with an Avalon-MM register port.
// Assumes pad cells resolve each pin from its _O and _OE_O signals.
//
// Function
// - Clock pins drive divided clocks after reset
// - Enable gives pin to GPIO; direction sets drive
// - Converter pin default; GPIO 8 when enabled
// - Shared video/audio pins idle after reset
// - Video enable alone routes shared pins to video
// - Audio enable alone routes shared pins to audio
// - Host pins 15:8 and 6:0 become MII when strap high; pin 7 stays host
// - Peripheral config writes need unlock key; then relock
// - Strap readable in status bit 11
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "pin_mux_defines.svh"

module pin_mux_top (
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// Avalon-MM slave
	input  wire logic [7:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Functions from the core
	input  wire logic        DIVIDED_CLOCK_OUT_A_I,
	input  wire logic        DIVIDED_CLOCK_OUT_B_I,
	input  wire logic        VCXO_CONVERTER_OUT_I,
	input  wire logic [7:0]  VIDEO_PORT1_DATA_OUT_I,
	input  wire logic [7:0]  VIDEO_PORT1_DATA_OE_I,
	output logic      [7:0]  VIDEO_PORT1_DATA_IN_O,
	input  wire logic [7:0]  AUDIO_PORT0_SERIAL_DATA_OUT_I,
	input  wire logic [7:0]  AUDIO_PORT0_SERIAL_DATA_OE_I,
	output logic      [7:0]  AUDIO_PORT0_SERIAL_DATA_IN_O,
	input  wire logic [15:0] HOST_DATA_OUT_I,
	input  wire logic        HOST_DATA_OE_I,
	output logic      [15:0] HOST_DATA_IN_O,
	input  wire logic [6:0]  MII_TX_I,
	output logic      [7:0]  MII_RX_O,
	output logic             ETHERNET_ENABLE_O,
	output logic             VIDEO_PORT1_ACTIVE_O,
	output logic             AUDIO_PORT0_ACTIVE_O,
	// Pins
	input  wire logic        CLK_A_PIN_I,
	output logic             CLK_A_PIN_O,
	output logic             CLK_A_PIN_OE_O,
	input  wire logic        CLK_B_PIN_I,
	output logic             CLK_B_PIN_O,
	output logic             CLK_B_PIN_OE_O,
	input  wire logic        CONV_PIN_I,
	output logic             CONV_PIN_O,
	output logic             CONV_PIN_OE_O,
	input  wire logic [7:0]  SHARED_PIN_I,
	output logic      [7:0]  SHARED_PIN_O,
	output logic      [7:0]  SHARED_PIN_OE_O,
	input  wire logic [15:0] HOST_DATA_PINS_I,
	output logic      [15:0] HOST_DATA_PINS_O,
	output logic      [15:0] HOST_DATA_PINS_OE_O,
	input  wire logic        ETHERNET_STRAP_I
);

	// ==========================================================
	// Helpers
	function automatic pin_mux_pkg::pin_drive_t gpio_or_func(
		input logic en,
		input logic dir,
		input logic gpio_val,
		input logic func_val
	);
		pin_mux_pkg::pin_drive_t d;
		if (en) begin
			d.o  = gpio_val;
			d.oe = dir;
		end else begin
			d.o  = func_val;
			d.oe = 1'b1;
		end
		return d;
	endfunction

	// ==========================================================
	// Pin input synchronisers and strap capture
	logic [27:0] pins_async;
	logic [27:0] pins_sync;
	logic        strap_sync;
	logic        eth_strap;

	assign pins_async = {ETHERNET_STRAP_I, HOST_DATA_PINS_I, SHARED_PIN_I,
		CONV_PIN_I, CLK_B_PIN_I, CLK_A_PIN_I};
	assign strap_sync = pins_sync[27];

	pin_sync #(
		.WIDTH(28)
	) u_sync (
		.clk_i  (CLK_I),
		.async_i(pins_async),
		.sync_o (pins_sync)
	);

	strap_latch u_strap (
		.clk_i  (CLK_I),
		.srst_i (SRST_I),
		.strap_i(strap_sync),
		.strap_o(eth_strap)
	);

	// ==========================================================
	// Avalon-MM slave and configuration registers
	pin_mux_pkg::cfg_state_t cfg_reg;
	pin_mux_pkg::cfg_state_t cfg_next;
	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        wr_take;
	logic        rd_start;
	logic [15:0] gpio_in;

	assign wr_take  = AVS_WRITE_I && !wait_reg;
	assign rd_start = AVS_READ_I && wait_reg;
	assign gpio_in  = {7'h00, pins_sync[2], 5'h00, pins_sync[1],
		pins_sync[0], 1'h0};

	always_comb begin
		cfg_next   = cfg_reg;
		rdata_next = rdata_reg;
		// One wait cycle, then a single ready cycle
		wait_next  = !((AVS_READ_I || AVS_WRITE_I) && wait_reg);
		if (wr_take) begin
			case (AVS_ADDRESS_I)
				`OFS_PERIPH_CFG: begin
					if (!cfg_reg.locked) begin
						cfg_next.periph_cfg = AVS_WRITEDATA_I[1:0];
					end
					cfg_next.locked = 1'b1;
				end
				`OFS_CFG_LOCK: begin
					cfg_next.locked = (AVS_WRITEDATA_I != `UNLOCK_KEY);
				end
				`OFS_GPIO_ENABLE: begin
					cfg_next.gpio_pin_enable = AVS_WRITEDATA_I[15:0] & `GPIO_MASK;
				end
				`OFS_GPIO_DIRECTION: begin
					cfg_next.gpio_pin_direction =
						AVS_WRITEDATA_I[15:0] & `GPIO_MASK;
				end
				`OFS_GPIO_OUT: begin
					cfg_next.gpio_out = AVS_WRITEDATA_I[15:0] & `GPIO_MASK;
				end
				default: begin
				end
			endcase
		end
		if (rd_start) begin
			rdata_next = 32'h0000_0000;
			case (AVS_ADDRESS_I)
				`OFS_PERIPH_CFG: begin
					rdata_next[1:0] = cfg_reg.periph_cfg;
				end
				`OFS_DEVICE_STATUS: begin
					rdata_next[`STATUS_ETH_BIT] = eth_strap;
				end
				`OFS_CFG_LOCK: begin
					rdata_next[0] = cfg_reg.locked;
				end
				`OFS_GPIO_ENABLE: begin
					rdata_next[15:0] = cfg_reg.gpio_pin_enable;
				end
				`OFS_GPIO_DIRECTION: begin
					rdata_next[15:0] = cfg_reg.gpio_pin_direction;
				end
				`OFS_GPIO_OUT: begin
					rdata_next[15:0] = cfg_reg.gpio_out;
				end
				`OFS_GPIO_IN: begin
					rdata_next[15:0] = gpio_in;
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			cfg_reg.periph_cfg         <= `PERIPH_CFG_RESET;
			cfg_reg.locked             <= `LOCK_RESET;
			cfg_reg.gpio_pin_enable    <= `GPIO_RESET;
			cfg_reg.gpio_pin_direction <= `GPIO_RESET;
			cfg_reg.gpio_out           <= `GPIO_RESET;
			wait_reg                   <= 1'b1;
			rdata_reg                  <= 32'h0000_0000;
		end else begin
			cfg_reg   <= cfg_next;
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign AVS_WAITREQUEST_O = wait_reg;
	assign AVS_READDATA_O    = rdata_reg;

	// ==========================================================
	// Pin function selection, every pin output registered
	pin_mux_pkg::shared_owner_t owner;
	pin_mux_pkg::pin_drive_t    clk_a_next;
	pin_mux_pkg::pin_drive_t    clk_b_next;
	pin_mux_pkg::pin_drive_t    conv_next;
	pin_mux_pkg::pin_drive_t    clk_a_reg;
	pin_mux_pkg::pin_drive_t    clk_b_reg;
	pin_mux_pkg::pin_drive_t    conv_reg;
	logic [7:0]  shared_o_next;
	logic [7:0]  shared_oe_next;
	logic [7:0]  shared_o_reg;
	logic [7:0]  shared_oe_reg;
	logic [7:0]  vid_in_next;
	logic [7:0]  aud_in_next;
	logic [7:0]  vid_in_reg;
	logic [7:0]  aud_in_reg;
	logic [15:0] host_o_next;
	logic [15:0] host_oe_next;
	logic [15:0] host_in_next;
	logic [15:0] host_o_reg;
	logic [15:0] host_oe_reg;
	logic [15:0] host_in_reg;
	logic [7:0]  mii_rx_next;
	logic [7:0]  mii_rx_reg;
	logic        vid_act_reg;
	logic        aud_act_reg;
	logic        eth_reg;

	always_comb begin
		// Both enables set is a misconfiguration: keep the pins quiet
		case (cfg_reg.periph_cfg)
			2'h2: owner = pin_mux_pkg::OWNER_VIDEO1;
			2'h1: owner = pin_mux_pkg::OWNER_AUDIO0;
			default: owner = pin_mux_pkg::OWNER_NONE;
		endcase

		clk_a_next = gpio_or_func(cfg_reg.gpio_pin_enable[`GPIO_CLK_A_BIT],
			cfg_reg.gpio_pin_direction[`GPIO_CLK_A_BIT],
			cfg_reg.gpio_out[`GPIO_CLK_A_BIT], DIVIDED_CLOCK_OUT_A_I);
		clk_b_next = gpio_or_func(cfg_reg.gpio_pin_enable[`GPIO_CLK_B_BIT],
			cfg_reg.gpio_pin_direction[`GPIO_CLK_B_BIT],
			cfg_reg.gpio_out[`GPIO_CLK_B_BIT], DIVIDED_CLOCK_OUT_B_I);
		conv_next = gpio_or_func(cfg_reg.gpio_pin_enable[`GPIO_CONV_BIT],
			cfg_reg.gpio_pin_direction[`GPIO_CONV_BIT],
			cfg_reg.gpio_out[`GPIO_CONV_BIT], VCXO_CONVERTER_OUT_I);

		shared_o_next  = 8'h00;
		shared_oe_next = 8'h00;
		vid_in_next    = 8'h00;
		aud_in_next    = 8'h00;
		case (owner)
			pin_mux_pkg::OWNER_VIDEO1: begin
				shared_o_next  = VIDEO_PORT1_DATA_OUT_I;
				shared_oe_next = VIDEO_PORT1_DATA_OE_I;
				vid_in_next    = pins_sync[10:3];
			end
			pin_mux_pkg::OWNER_AUDIO0: begin
				shared_o_next  = AUDIO_PORT0_SERIAL_DATA_OUT_I;
				shared_oe_next = AUDIO_PORT0_SERIAL_DATA_OE_I;
				aud_in_next    = pins_sync[10:3];
			end
			default: begin
			end
		endcase

		// Pins 15:8 become MII receive, 6:0 MII transmit
		host_o_next  = HOST_DATA_OUT_I;
		host_oe_next = {16{HOST_DATA_OE_I}};
		host_in_next = pins_sync[26:11];
		mii_rx_next  = 8'h00;
		if (eth_strap) begin
			host_o_next  = (HOST_DATA_OUT_I & ~`HOST_MII_TX_MASK)
				| {9'h000, MII_TX_I};
			host_oe_next = (host_oe_next & ~`HOST_MII_RX_MASK)
				| `HOST_MII_TX_MASK;
			host_in_next = pins_sync[26:11]
				& ~(`HOST_MII_RX_MASK | `HOST_MII_TX_MASK);
			mii_rx_next  = pins_sync[26:19];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			clk_a_reg     <= '{o: 1'b0, oe: 1'b1};
			clk_b_reg     <= '{o: 1'b0, oe: 1'b1};
			conv_reg      <= '{o: 1'b0, oe: 1'b1};
			shared_o_reg  <= 8'h00;
			shared_oe_reg <= 8'h00;
			vid_in_reg    <= 8'h00;
			aud_in_reg    <= 8'h00;
			host_o_reg    <= 16'h0000;
			host_oe_reg   <= 16'h0000;
			host_in_reg   <= 16'h0000;
			mii_rx_reg    <= 8'h00;
			vid_act_reg   <= 1'b0;
			aud_act_reg   <= 1'b0;
			eth_reg       <= 1'b0;
		end else begin
			clk_a_reg     <= clk_a_next;
			clk_b_reg     <= clk_b_next;
			conv_reg      <= conv_next;
			shared_o_reg  <= shared_o_next;
			shared_oe_reg <= shared_oe_next;
			vid_in_reg    <= vid_in_next;
			aud_in_reg    <= aud_in_next;
			host_o_reg    <= host_o_next;
			host_oe_reg   <= host_oe_next;
			host_in_reg   <= host_in_next;
			mii_rx_reg    <= mii_rx_next;
			vid_act_reg   <= (owner == pin_mux_pkg::OWNER_VIDEO1);
			aud_act_reg   <= (owner == pin_mux_pkg::OWNER_AUDIO0);
			eth_reg       <= eth_strap;
		end
	end

	// ==========================================================
	// Outputs
	assign CLK_A_PIN_O                  = clk_a_reg.o;
	assign CLK_A_PIN_OE_O               = clk_a_reg.oe;
	assign CLK_B_PIN_O                  = clk_b_reg.o;
	assign CLK_B_PIN_OE_O               = clk_b_reg.oe;
	assign CONV_PIN_O                   = conv_reg.o;
	assign CONV_PIN_OE_O                = conv_reg.oe;
	assign SHARED_PIN_O                 = shared_o_reg;
	assign SHARED_PIN_OE_O              = shared_oe_reg;
	assign VIDEO_PORT1_DATA_IN_O        = vid_in_reg;
	assign AUDIO_PORT0_SERIAL_DATA_IN_O = aud_in_reg;
	assign HOST_DATA_PINS_O             = host_o_reg;
	assign HOST_DATA_PINS_OE_O          = host_oe_reg;
	assign HOST_DATA_IN_O               = host_in_reg;
	assign MII_RX_O                     = mii_rx_reg;
	assign VIDEO_PORT1_ACTIVE_O         = vid_act_reg;
	assign AUDIO_PORT0_ACTIVE_O         = aud_act_reg;
	assign ETHERNET_ENABLE_O            = eth_reg;

endmodule

// ==== bench/pin_mux_monitor.sv ====
// Port checker for the pin-mux top.
// Assumes bind onto pin_mux_top; sees its ports only.
`timescale 1ns/1ps
module pin_mux_monitor (
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        DIVIDED_CLOCK_OUT_A_I,
	input wire logic        DIVIDED_CLOCK_OUT_B_I,
	input wire logic        VCXO_CONVERTER_OUT_I,
	input wire logic [7:0]  VIDEO_PORT1_DATA_OUT_I,
	input wire logic [7:0]  VIDEO_PORT1_DATA_OE_I,
	input wire logic [7:0]  AUDIO_PORT0_SERIAL_DATA_OUT_I,
	input wire logic [7:0]  AUDIO_PORT0_SERIAL_DATA_OE_I,
	input wire logic        HOST_DATA_OE_I,
	input wire logic [6:0]  MII_TX_I,
	input wire logic        ETHERNET_ENABLE_O,
	input wire logic        VIDEO_PORT1_ACTIVE_O,
	input wire logic        AUDIO_PORT0_ACTIVE_O,
	input wire logic        CLK_A_PIN_O,
	input wire logic        CLK_A_PIN_OE_O,
	input wire logic        CLK_B_PIN_O,
	input wire logic        CLK_B_PIN_OE_O,
	input wire logic        CONV_PIN_O,
	input wire logic        CONV_PIN_OE_O,
	input wire logic [7:0]  SHARED_PIN_O,
	input wire logic [7:0]  SHARED_PIN_OE_O,
	input wire logic [15:0] HOST_DATA_PINS_O,
	input wire logic [15:0] HOST_DATA_PINS_OE_O
);
	// ==========================================================
	// Sequences
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	sequence s_release;
		$past(SRST_I) && !SRST_I;
	endsequence
	sequence s_answer;
		!AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
	endsequence
	// ==========================================================
	// Properties
	property p_fixed_func;
		s_release |=> CLK_A_PIN_OE_O && CLK_B_PIN_OE_O && CONV_PIN_OE_O
			&& CLK_A_PIN_O == $past(DIVIDED_CLOCK_OUT_A_I)
			&& CLK_B_PIN_O == $past(DIVIDED_CLOCK_OUT_B_I)
			&& CONV_PIN_O == $past(VCXO_CONVERTER_OUT_I);
	endproperty
	a_fixed_func: assert property (p_fixed_func)
		else $error("pin function wrong after reset");
	property p_idle;
		!VIDEO_PORT1_ACTIVE_O && !AUDIO_PORT0_ACTIVE_O
			|-> SHARED_PIN_OE_O == 8'h00;
	endproperty
	a_idle: assert property (p_idle)
		else $error("shared pins driven with no owner");
	property p_video;
		VIDEO_PORT1_ACTIVE_O |-> !AUDIO_PORT0_ACTIVE_O
			&& SHARED_PIN_OE_O == $past(VIDEO_PORT1_DATA_OE_I)
			&& (SHARED_PIN_O & SHARED_PIN_OE_O)
			== ($past(VIDEO_PORT1_DATA_OUT_I) & SHARED_PIN_OE_O);
	endproperty
	a_video: assert property (p_video)
		else $error("shared pins not on video");
	property p_audio;
		AUDIO_PORT0_ACTIVE_O |-> !VIDEO_PORT1_ACTIVE_O
			&& SHARED_PIN_OE_O == $past(AUDIO_PORT0_SERIAL_DATA_OE_I)
			&& (SHARED_PIN_O & SHARED_PIN_OE_O)
			== ($past(AUDIO_PORT0_SERIAL_DATA_OUT_I) & SHARED_PIN_OE_O);
	endproperty
	a_audio: assert property (p_audio)
		else $error("shared pins not on audio");
	property p_mii;
		ETHERNET_ENABLE_O && $past(ETHERNET_ENABLE_O)
			|-> HOST_DATA_PINS_OE_O[15:8] == 8'h00
			&& HOST_DATA_PINS_OE_O[6:0] == 7'h7f
			&& HOST_DATA_PINS_O[6:0] == $past(MII_TX_I);
	endproperty
	a_mii: assert property (p_mii)
		else $error("host pins not on network mapping");
	property p_host;
		!ETHERNET_ENABLE_O && !$past(SRST_I)
			|-> HOST_DATA_PINS_OE_O == {16{$past(HOST_DATA_OE_I)}};
	endproperty
	a_host: assert property (p_host)
		else $error("host pin enables wrong");
	// Strap may settle two edges after release, then never moves
	property p_strap_hold;
		!SRST_I [*4] |-> $stable(ETHERNET_ENABLE_O);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("latched strap changed");
	property p_answer;
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> s_answer;
	endproperty
	a_answer: assert property (p_answer)
		else $error("register access not answered in one cycle");
endmodule

// ==== bench/pin_partner.sv ====
// Board model: strap pull and read-back of every clk, conv, shared and host pin.
// Assumes pins packed as clk a, clk b, conv, shared, host.
`timescale 1ns/1ps
module pin_partner (
	input  wire logic        strap_level_i,
	input  wire logic [26:0] pin_o_i,
	input  wire logic [26:0] pin_oe_i,
	output logic      [26:0] pin_level_o,
	output logic             strap_o
);
	// Released lines read back inverted, so a stale drive never matches
	assign pin_level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ~pin_o_i);
	assign strap_o = strap_level_i;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the pin-mux block.
// Assumes design, checker and board model compiled first.
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals
	typedef struct packed {
		logic [15:0] en;
		logic [15:0] dir;
		logic [15:0] out;
		logic [5:0]  msk;
		logic [5:0]  exp;
		logic [15:0] gin;
	} gpio_row_t;
	gpio_row_t rows [4] = '{
		'{16'h0000, 16'h0000, 16'h0000, 6'h3f, 6'h3b, 16'h0102},
		'{16'h0106, 16'h0106, 16'h0002, 6'h3f, 6'h3a, 16'h0002},
		'{16'h0106, 16'h0000, 16'h0106, 6'h2a, 6'h00, 16'h0000},
		'{16'h0004, 16'h0106, 16'h0104, 6'h3f, 6'h3f, 16'h0106}};
	logic CLK_I, SRST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
	logic DIVIDED_CLOCK_OUT_A_I, DIVIDED_CLOCK_OUT_B_I;
	logic VCXO_CONVERTER_OUT_I, HOST_DATA_OE_I, ETHERNET_ENABLE_O;
	logic VIDEO_PORT1_ACTIVE_O, AUDIO_PORT0_ACTIVE_O, strap;
	logic CLK_A_PIN_I, CLK_A_PIN_O, CLK_A_PIN_OE_O, CLK_B_PIN_I;
	logic CLK_B_PIN_O, CLK_B_PIN_OE_O, CONV_PIN_I, CONV_PIN_O;
	logic CONV_PIN_OE_O, ETHERNET_STRAP_I;
	logic [6:0]  MII_TX_I;
	logic [7:0]  AVS_ADDRESS_I, MII_RX_O, SHARED_PIN_I, SHARED_PIN_O;
	logic [7:0]  SHARED_PIN_OE_O, VIDEO_PORT1_DATA_OUT_I;
	logic [7:0]  VIDEO_PORT1_DATA_OE_I, VIDEO_PORT1_DATA_IN_O;
	logic [7:0]  AUDIO_PORT0_SERIAL_DATA_OUT_I, AUDIO_PORT0_SERIAL_DATA_OE_I;
	logic [7:0]  AUDIO_PORT0_SERIAL_DATA_IN_O;
	logic [15:0] HOST_DATA_OUT_I, HOST_DATA_IN_O, HOST_DATA_PINS_I;
	logic [15:0] HOST_DATA_PINS_O, HOST_DATA_PINS_OE_O;
	logic [26:0] pin_level;
	logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, q;
	logic [17:0] want;
	int          num_errors = 0;
	int          comparisons = 0;
	pin_mux_top dut_u (.CLK_I(CLK_I), .SRST_I(SRST_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
		.AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
		.AVS_READDATA_O(AVS_READDATA_O),
		.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.DIVIDED_CLOCK_OUT_A_I(DIVIDED_CLOCK_OUT_A_I),
		.DIVIDED_CLOCK_OUT_B_I(DIVIDED_CLOCK_OUT_B_I),
		.VCXO_CONVERTER_OUT_I(VCXO_CONVERTER_OUT_I),
		.VIDEO_PORT1_DATA_OUT_I(VIDEO_PORT1_DATA_OUT_I),
		.VIDEO_PORT1_DATA_OE_I(VIDEO_PORT1_DATA_OE_I),
		.VIDEO_PORT1_DATA_IN_O(VIDEO_PORT1_DATA_IN_O),
		.AUDIO_PORT0_SERIAL_DATA_OUT_I(AUDIO_PORT0_SERIAL_DATA_OUT_I),
		.AUDIO_PORT0_SERIAL_DATA_OE_I(AUDIO_PORT0_SERIAL_DATA_OE_I),
		.AUDIO_PORT0_SERIAL_DATA_IN_O(AUDIO_PORT0_SERIAL_DATA_IN_O),
		.HOST_DATA_OUT_I(HOST_DATA_OUT_I), .HOST_DATA_OE_I(HOST_DATA_OE_I),
		.HOST_DATA_IN_O(HOST_DATA_IN_O), .MII_TX_I(MII_TX_I),
		.MII_RX_O(MII_RX_O), .ETHERNET_ENABLE_O(ETHERNET_ENABLE_O),
		.VIDEO_PORT1_ACTIVE_O(VIDEO_PORT1_ACTIVE_O),
		.AUDIO_PORT0_ACTIVE_O(AUDIO_PORT0_ACTIVE_O),
		.CLK_A_PIN_I(CLK_A_PIN_I), .CLK_A_PIN_O(CLK_A_PIN_O),
		.CLK_A_PIN_OE_O(CLK_A_PIN_OE_O), .CLK_B_PIN_I(CLK_B_PIN_I),
		.CLK_B_PIN_O(CLK_B_PIN_O), .CLK_B_PIN_OE_O(CLK_B_PIN_OE_O),
		.CONV_PIN_I(CONV_PIN_I), .CONV_PIN_O(CONV_PIN_O),
		.CONV_PIN_OE_O(CONV_PIN_OE_O), .SHARED_PIN_I(SHARED_PIN_I),
		.SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE_O(SHARED_PIN_OE_O),
		.HOST_DATA_PINS_I(HOST_DATA_PINS_I),
		.HOST_DATA_PINS_O(HOST_DATA_PINS_O),
		.HOST_DATA_PINS_OE_O(HOST_DATA_PINS_OE_O),
		.ETHERNET_STRAP_I(ETHERNET_STRAP_I));
	pin_partner peer_u (.strap_level_i(strap),
		.pin_o_i({CLK_A_PIN_O, CLK_B_PIN_O, CONV_PIN_O, SHARED_PIN_O,
			HOST_DATA_PINS_O}),
		.pin_oe_i({CLK_A_PIN_OE_O, CLK_B_PIN_OE_O, CONV_PIN_OE_O,
			SHARED_PIN_OE_O, HOST_DATA_PINS_OE_O}),
		.pin_level_o(pin_level), .strap_o(ETHERNET_STRAP_I));
	assign {CLK_A_PIN_I, CLK_B_PIN_I, CONV_PIN_I, SHARED_PIN_I,
		HOST_DATA_PINS_I} = pin_level;
	// ==========================================================
	// Tasks
	function automatic logic [5:0] pins();
		return {CLK_A_PIN_OE_O, CLK_A_PIN_O, CLK_B_PIN_OE_O, CLK_B_PIN_O,
			CONV_PIN_OE_O, CONV_PIN_O};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_I);
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= wr;
		AVS_READ_I <= !wr;
		// No limit here: only the watchdog ends a hung wait
		do begin
			@(posedge CLK_I);
		end while (AVS_WAITREQUEST_O !== 1'b0);
		q = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task automatic do_reset();
		SRST_I <= 1'b1;
		tick(16);
		SRST_I <= 1'b0;
		tick(4);
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog, tests
	initial begin
		CLK_I = 1'b0;
		forever #12.5 CLK_I = ~CLK_I;
	end
	initial begin
		tick(5000);
		num_errors++;
		print_verdict();
	end
	initial begin
		{SRST_I, AVS_READ_I, AVS_WRITE_I, AVS_ADDRESS_I} = 11'h400;
		AVS_WRITEDATA_I = 32'h0;
		{DIVIDED_CLOCK_OUT_A_I, DIVIDED_CLOCK_OUT_B_I} = 2'h2;
		{VCXO_CONVERTER_OUT_I, HOST_DATA_OE_I, strap} = 3'h6;
		{VIDEO_PORT1_DATA_OUT_I, VIDEO_PORT1_DATA_OE_I} = 16'ha5f0;
		{AUDIO_PORT0_SERIAL_DATA_OUT_I, AUDIO_PORT0_SERIAL_DATA_OE_I} = 16'h3c0f;
		HOST_DATA_OUT_I = 16'h1234;
		MII_TX_I = 7'h55;
		do_reset();
		chk(32'(pins()), 32'h3b);
		chk(32'(SHARED_PIN_OE_O), 32'h0);
		chk(32'({HOST_DATA_PINS_OE_O, HOST_DATA_PINS_O}), 32'hffff1234);
		bus(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0);
		chk(32'(ETHERNET_ENABLE_O), 32'h0);
		bus(1'b0, 8'h08, 32'h0);
		chk(q, 32'h1);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		chk({HOST_DATA_IN_O, 8'h00, MII_RX_O}, 32'h1234_0000);
		foreach (rows[i]) begin
			bus(1'b1, 8'h0c, 32'(rows[i].en));
			bus(1'b1, 8'h10, 32'(rows[i].dir));
			bus(1'b1, 8'h14, 32'(rows[i].out));
			tick(2);
			chk(32'(pins() & rows[i].msk), 32'(rows[i].exp));
			bus(1'b0, 8'h0c, 32'h0);
			chk(q, 32'(rows[i].en & 16'h0106));
			bus(1'b0, 8'h18, 32'h0);
			chk(q, 32'(rows[i].gin));
		end
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'h08, 32'h10c0010c);
			bus(1'b1, 8'h00, 32'(c));
			tick(2);
			want = (c == 2) ? 18'h2f0a0 : (c == 1) ? 18'h10f0c : 18'h0;
			chk(32'({VIDEO_PORT1_ACTIVE_O, AUDIO_PORT0_ACTIVE_O,
				SHARED_PIN_OE_O, SHARED_PIN_O & SHARED_PIN_OE_O}), 32'(want));
			bus(1'b0, 8'h00, 32'h0);
			chk(q, 32'(c));
			want = (c == 2) ? 18'h0aa00 : (c == 1) ? 18'h000cc : 18'h0;
			chk(32'({VIDEO_PORT1_DATA_IN_O, AUDIO_PORT0_SERIAL_DATA_IN_O}),
				32'(want));
			bus(1'b0, 8'h08, 32'h0);
			chk(q, 32'h1);
		end
		// Locked write must leave the peripheral config register reading 3
		bus(1'b1, 8'h00, 32'h2);
		bus(1'b0, 8'h00, 32'h0);
		chk(q, 32'h3);
		strap <= 1'b1;
		do_reset();
		bus(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0000_0800);
		chk(32'(ETHERNET_ENABLE_O), 32'h1);
		chk({HOST_DATA_PINS_OE_O, 9'h0, HOST_DATA_PINS_O[6:0]}, 32'h00ff0055);
		chk({HOST_DATA_IN_O, 8'h00, MII_RX_O}, 32'h0000_00ed);
		bus(1'b0, 8'h00, 32'h0);
		chk({q[30:0], |SHARED_PIN_OE_O}, 32'h0);
		strap <= 1'b0;
		tick(8);
		bus(1'b0, 8'h04, 32'h0);
		chk(q, 32'h0000_0800);
		chk(32'(ETHERNET_ENABLE_O), 32'h1);
		print_verdict();
	end
endmodule
bind pin_mux_top pin_mux_monitor mon_u (.CLK_I(CLK_I), .SRST_I(SRST_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.DIVIDED_CLOCK_OUT_A_I(DIVIDED_CLOCK_OUT_A_I),
	.DIVIDED_CLOCK_OUT_B_I(DIVIDED_CLOCK_OUT_B_I),
	.VCXO_CONVERTER_OUT_I(VCXO_CONVERTER_OUT_I),
	.VIDEO_PORT1_DATA_OUT_I(VIDEO_PORT1_DATA_OUT_I),
	.VIDEO_PORT1_DATA_OE_I(VIDEO_PORT1_DATA_OE_I),
	.AUDIO_PORT0_SERIAL_DATA_OUT_I(AUDIO_PORT0_SERIAL_DATA_OUT_I),
	.AUDIO_PORT0_SERIAL_DATA_OE_I(AUDIO_PORT0_SERIAL_DATA_OE_I),
	.HOST_DATA_OE_I(HOST_DATA_OE_I), .MII_TX_I(MII_TX_I),
	.ETHERNET_ENABLE_O(ETHERNET_ENABLE_O),
	.VIDEO_PORT1_ACTIVE_O(VIDEO_PORT1_ACTIVE_O),
	.AUDIO_PORT0_ACTIVE_O(AUDIO_PORT0_ACTIVE_O),
	.CLK_A_PIN_O(CLK_A_PIN_O), .CLK_A_PIN_OE_O(CLK_A_PIN_OE_O),
	.CLK_B_PIN_O(CLK_B_PIN_O), .CLK_B_PIN_OE_O(CLK_B_PIN_OE_O),
	.CONV_PIN_O(CONV_PIN_O), .CONV_PIN_OE_O(CONV_PIN_OE_O),
	.SHARED_PIN_O(SHARED_PIN_O), .SHARED_PIN_OE_O(SHARED_PIN_OE_O),
	.HOST_DATA_PINS_O(HOST_DATA_PINS_O),
	.HOST_DATA_PINS_OE_O(HOST_DATA_PINS_OE_O));
